// >>> design/acb_aux_bank.v
// auxiliary control and status register bank with AXI4-Lite access
`timescale 1ns/1ns
`include "acb_regs.vh"
module acb_aux_bank #(
  parameter TICK_CYCLES = `ACB_INTERVAL_UNIT_US * `ACB_CLK_MHZ
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // axi4-lite write address and data
  input  wire [11:0] s_axi_awaddr_i,
  input  wire [2:0]  s_axi_awprot_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr_i,
  input  wire [2:0]  s_axi_arprot_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // system status pins
  input  wire        tool_sel_i,
  input  wire        mem_lost_i,
  input  wire        err_logged_i,
  input  wire        is_motion_i,
  // trace and monitor events
  input  wire        diff_mon_start_i,
  input  wire        diff_mon_hit_i,
  input  wire        trace_region_full_i,
  input  wire        trace_finished_i,
  input  wire        trace_sample_instr_i,
  input  wire        cycle_end_i,
  // serial ports
  input  wire [2:0]  port_restart_done_i,
  input  wire [3:0]  serial_err_i,
  input  wire [3:0]  periph_err_i,
  // interrupt counter 0
  input  wire        irq_in0_i,
  input  wire        counter_mode_i,
  // outputs toward the module
  output reg  [15:0] error_log_pointer_o,
  output reg  [15:0] bus_unit_restart_o,
  output reg  [95:0] special_unit_restart_o,
  output reg  [2:0]  port_restart_o,
  output reg         edit_refuse_o,
  output reg         trace_sample_o,
  output reg         trace_sample_valid_o,
  output reg         trace_trigger_o,
  output reg         irq_task0_o
);

  localparam NSYNC = 23;

  // two-flop synchronisers for all pin inputs
  reg  [NSYNC-1:0] sync1_r;
  reg  [NSYNC-1:0] sync2_r;
  reg  [NSYNC-1:0] prev_r;
  wire [NSYNC-1:0] pins;
  assign pins = {tool_sel_i, mem_lost_i, err_logged_i, is_motion_i, diff_mon_start_i,
                 diff_mon_hit_i, trace_region_full_i, trace_finished_i,
                 trace_sample_instr_i, cycle_end_i, port_restart_done_i, serial_err_i,
                 periph_err_i, irq_in0_i, counter_mode_i};
  always @(posedge clk_i)
  begin
    sync1_r <= pins;
    sync2_r <= sync1_r;
    prev_r  <= sync2_r;
  end
  wire [NSYNC-1:0] rise = sync2_r & ~prev_r;
  wire       tool_sel    = sync2_r[22];
  wire       mem_lost    = rise[21];
  wire       err_logged  = rise[20];
  wire       is_motion   = sync2_r[19];
  wire       diff_start  = rise[18];
  wire       diff_hit    = rise[17];
  wire       region_full = rise[16];
  wire       tr_finished = rise[15];
  wire       instr_evt   = rise[14];
  wire       cyc_evt     = rise[13];
  wire [2:0] pr_done     = rise[12:10];
  wire [3:0] ser_err     = rise[9:6];
  wire [3:0] per_err     = rise[5:2];
  wire       irq_edge    = rise[1];
  wire       cnt_mode    = sync2_r[0];

  // register state
  reg        log_reset_r;
  reg        not_held_r;
  reg [15:0] trace_r;
  reg [15:0] lock_r;
  reg [15:0] port_err_r;
  reg [15:0] setpoint_r;
  reg [15:0] present_r;
  reg [15:0] trace_cfg_r;
  reg [15:0] trace_delay_r;
  reg        start_prev_r;
  reg        trig_prev_r;
  reg [31:0] tick_cnt_r;
  reg [7:0]  unit_cnt_r;
  reg [15:0] after_trig_r;

  // byte-lane merge of a 16-bit word
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // word index decode with mapped flag
  function mapped;
    input [9:0] idx;
    begin
      mapped = (idx >= `ACB_IDX_AREA_ID_FIRST && idx <= `ACB_IDX_AREA_ID_LAST) ||
               (idx >= `ACB_IDX_LOG_CTRL && idx <= `ACB_IDX_TRACE) ||
               idx == `ACB_IDX_PORT_RESTART || idx == `ACB_IDX_EDIT_LOCK ||
               idx == `ACB_IDX_PORT_ERR || idx == `ACB_IDX_CNT0_SETPOINT ||
               idx == `ACB_IDX_CNT0_PRESENT || idx == `ACB_IDX_TRACE_CFG ||
               idx == `ACB_IDX_TRACE_DELAY || idx == `ACB_IDX_LOG_PTR;
    end
  endfunction

  // axi write channel capture
  reg        aw_got_r;
  reg        w_got_r;
  reg [9:0]  wr_idx_r;
  reg [31:0] wr_data_r;
  reg [3:0]  wr_strb_r;
  wire       wr_go = aw_got_r && w_got_r && !s_axi_bvalid_o;
  wire       wr_ok = wr_go && mapped(wr_idx_r);

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      wr_idx_r        <= 10'h000;
      wr_data_r       <= 32'h0000_0000;
      wr_strb_r       <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `ACB_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got_r        <= 1'b1;
        wr_idx_r        <= s_axi_awaddr_i[11:2];
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got_r        <= 1'b1;
        wr_data_r      <= s_axi_wdata_i;
        wr_strb_r      <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go)
      begin
        aw_got_r       <= 1'b0;
        w_got_r        <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= mapped(wr_idx_r) ? `ACB_RESP_OKAY : `ACB_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // axi read path
  reg [15:0] rd_word;
  wire [9:0] rd_idx = s_axi_araddr_i[11:2];
  integer k;
  always @*
  begin
    rd_word = 16'h0000;
    if (rd_idx >= `ACB_IDX_AREA_ID_FIRST && rd_idx <= `ACB_IDX_AREA_ID_LAST)
      rd_word = `ACB_AREA_ID_BASE + {6'h00, rd_idx - `ACB_IDX_AREA_ID_FIRST};
    for (k = 0; k < 6; k = k + 1)
      if (rd_idx == `ACB_IDX_SPEC_FIRST + k[9:0])
        rd_word = special_unit_restart_o[k*16 +: 16];
    case (rd_idx)
      `ACB_IDX_LOG_CTRL:      rd_word = {not_held_r, log_reset_r, 14'h0000};
      `ACB_IDX_BUS_RESTART:   rd_word = bus_unit_restart_o;
      `ACB_IDX_TRACE:         rd_word = trace_r;
      `ACB_IDX_PORT_RESTART:  rd_word = {8'h00, port_restart_o[2], 5'h00, port_restart_o[1:0]};
      `ACB_IDX_EDIT_LOCK:     rd_word = lock_r;
      `ACB_IDX_PORT_ERR:      rd_word = port_err_r;
      `ACB_IDX_CNT0_SETPOINT: rd_word = setpoint_r;
      `ACB_IDX_CNT0_PRESENT:  rd_word = present_r;
      `ACB_IDX_TRACE_CFG:     rd_word = trace_cfg_r;
      `ACB_IDX_TRACE_DELAY:   rd_word = trace_delay_r;
      `ACB_IDX_LOG_PTR:       rd_word = error_log_pointer_o;
      default:                rd_word = rd_word;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `ACB_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= {16'h0000, rd_word};
      s_axi_rresp_o   <= mapped(rd_idx) ? `ACB_RESP_OKAY : `ACB_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // write enables per register
  wire we_log   = wr_ok && wr_idx_r == `ACB_IDX_LOG_CTRL;
  wire we_bus   = wr_ok && wr_idx_r == `ACB_IDX_BUS_RESTART;
  wire we_trace = wr_ok && wr_idx_r == `ACB_IDX_TRACE;
  wire we_port  = wr_ok && wr_idx_r == `ACB_IDX_PORT_RESTART;
  wire we_lock  = wr_ok && wr_idx_r == `ACB_IDX_EDIT_LOCK;
  wire we_perr  = wr_ok && wr_idx_r == `ACB_IDX_PORT_ERR;
  wire we_sp    = wr_ok && wr_idx_r == `ACB_IDX_CNT0_SETPOINT;
  wire we_cfg   = wr_ok && wr_idx_r == `ACB_IDX_TRACE_CFG;
  wire we_dly   = wr_ok && wr_idx_r == `ACB_IDX_TRACE_DELAY;
  wire [15:0] wv_log   = merge16({not_held_r, log_reset_r, 14'h0000}, wr_data_r, wr_strb_r);
  wire [15:0] wv_trace = merge16(trace_r, wr_data_r, wr_strb_r);
  wire [15:0] wv_port  = merge16({8'h00, port_restart_o[2], 5'h00, port_restart_o[1:0]},
                                 wr_data_r, wr_strb_r);
  wire [15:0] wv_perr  = merge16(16'h0000, wr_data_r, wr_strb_r);

  // log pointer reset and memory-not-held flag
  reg  log_prev_r;
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      log_reset_r         <= 1'b0;
      log_prev_r          <= 1'b0;
      not_held_r          <= 1'b0;
      error_log_pointer_o <= `ACB_RESET_WORD;
    end
    else
    begin
      if (we_log)
        log_reset_r <= wv_log[`ACB_LOG_RESET_BIT];
      log_prev_r <= log_reset_r;
      if (log_reset_r && !log_prev_r)
      begin
        error_log_pointer_o <= `ACB_RESET_WORD;
        not_held_r          <= 1'b0;
      end
      else if (err_logged)
        error_log_pointer_o <= error_log_pointer_o + 16'h0001;
      if (mem_lost)
        not_held_r <= 1'b1;
    end
  end

  // unit restart requests held until software clears them
  integer m;
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      bus_unit_restart_o     <= `ACB_RESET_WORD;
      special_unit_restart_o <= 96'h0;
    end
    else
    begin
      if (we_bus)
        bus_unit_restart_o <= merge16(bus_unit_restart_o, wr_data_r, wr_strb_r);
      for (m = 0; m < 6; m = m + 1)
        if (wr_ok && wr_idx_r == `ACB_IDX_SPEC_FIRST + m[9:0])
          special_unit_restart_o[m*16 +: 16] <=
            merge16(special_unit_restart_o[m*16 +: 16], wr_data_r, wr_strb_r);
      special_unit_restart_o[`ACB_SPEC_FIRST_UNIT-1:0] <= 10'h000;
    end
  end

  // trace flags, sampling start and trigger
  wire start_rise = trace_r[`ACB_TR_START_BIT] && !start_prev_r;
  wire trig_rise  = trace_r[`ACB_TR_TRIGGER_BIT] && !trig_prev_r;
  wire [1:0] method = trace_cfg_r[`ACB_CFG_METHOD_LSB +: 2];
  wire [7:0] interval = trace_cfg_r[`ACB_CFG_INTERVAL_LSB +: 8];
  wire tick_end = tick_cnt_r == TICK_CYCLES - 1;
  wire unit_end = unit_cnt_r + 8'h01 >= interval;
  reg  sample_evt;
  always @*
  begin
    case (method)
      `ACB_METHOD_INTERVAL:  sample_evt = tick_end && unit_end;
      `ACB_METHOD_INSTR:     sample_evt = instr_evt;
      `ACB_METHOD_CYCLE_END: sample_evt = cyc_evt;
      default:               sample_evt = 1'b0;
    endcase
  end
  wire busy = trace_r[`ACB_TR_BUSY_BIT];
  wire [15:0] delay_mag = trace_delay_r[15] ? 16'h0000 : trace_delay_r;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      trace_r              <= `ACB_RESET_WORD;
      trace_cfg_r          <= `ACB_RESET_CFG;
      trace_delay_r        <= `ACB_RESET_WORD;
      start_prev_r         <= 1'b0;
      trig_prev_r          <= 1'b0;
      tick_cnt_r           <= 32'h0;
      unit_cnt_r           <= 8'h00;
      after_trig_r         <= 16'h0000;
      trace_sample_o       <= 1'b0;
      trace_sample_valid_o <= 1'b0;
      trace_trigger_o      <= 1'b0;
    end
    else
    begin
      if (we_cfg)
        trace_cfg_r <= merge16(trace_cfg_r, wr_data_r, wr_strb_r);
      if (we_dly)
        trace_delay_r <= merge16(trace_delay_r, wr_data_r, wr_strb_r);
      if (we_trace)
      begin
        trace_r[`ACB_TR_TRIGGER_BIT] <= wv_trace[`ACB_TR_TRIGGER_BIT];
        if (tool_sel)
          trace_r[`ACB_TR_START_BIT] <= wv_trace[`ACB_TR_START_BIT];
      end
      start_prev_r <= trace_r[`ACB_TR_START_BIT];
      trig_prev_r  <= trace_r[`ACB_TR_TRIGGER_BIT];
      // clears first, sets below win
      if (diff_start)
        trace_r[`ACB_TR_DIFF_DONE_BIT] <= 1'b0;
      if (diff_hit)
        trace_r[`ACB_TR_DIFF_DONE_BIT] <= 1'b1;
      if (start_rise)
      begin
        trace_r[`ACB_TR_TRIG_SEEN_BIT] <= 1'b0;
        trace_r[`ACB_TR_DONE_BIT]      <= 1'b0;
        after_trig_r                   <= 16'h0000;
      end
      if (busy && trig_rise)
        trace_r[`ACB_TR_TRIG_SEEN_BIT] <= 1'b1;
      if (busy && region_full)
        trace_r[`ACB_TR_DONE_BIT] <= 1'b1;
      if (tr_finished)
        trace_r[`ACB_TR_BUSY_BIT] <= 1'b0;
      if (start_rise)
        trace_r[`ACB_TR_BUSY_BIT] <= 1'b1;
      // interval timebase in 10 ms units
      if (start_rise || tick_end)
        tick_cnt_r <= 32'h0;
      else
        tick_cnt_r <= tick_cnt_r + 32'h1;
      if (start_rise || (tick_end && unit_end))
        unit_cnt_r <= 8'h00;
      else if (tick_end)
        unit_cnt_r <= unit_cnt_r + 8'h01;
      trace_sample_o  <= busy && sample_evt;
      trace_trigger_o <= busy && trig_rise;
      // negative delay keeps pre-trigger samples, positive skips samples after it
      trace_sample_valid_o <= busy && sample_evt &&
                              (trace_delay_r[15] ||
                               (trace_r[`ACB_TR_TRIG_SEEN_BIT] && after_trig_r >= delay_mag));
      if (busy && sample_evt && trace_r[`ACB_TR_TRIG_SEEN_BIT] && after_trig_r != 16'hffff)
        after_trig_r <= after_trig_r + 16'h0001;
    end
  end

  // port restarts, edit lock, port error flags
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      port_restart_o <= 3'h0;
      lock_r         <= `ACB_RESET_WORD;
      edit_refuse_o  <= 1'b0;
      port_err_r     <= `ACB_RESET_WORD;
    end
    else
    begin
      port_restart_o <= port_restart_o & ~pr_done;
      if (we_port)
        port_restart_o <= (port_restart_o & ~pr_done) |
                          {wv_port[`ACB_PR_DIFF_BIT], wv_port[`ACB_PR_PERIPH_BIT],
                           wv_port[`ACB_PR_SERIAL_BIT]};
      if (we_lock)
        lock_r <= merge16(lock_r, wr_data_r, wr_strb_r) & 16'h02ff;
      edit_refuse_o <= lock_r[`ACB_LOCK_BIT] &&
                       lock_r[7:0] == `ACB_LOCK_VALIDATOR;
      // write one to clear, a new error wins over the clear
      port_err_r <= (port_err_r & ~(we_perr ? wv_perr : 16'h0000)) |
                    ({12'h000, ser_err} << `ACB_PE_SERIAL_LSB) |
                    ({12'h000, per_err} << `ACB_PE_PERIPH_LSB);
    end
  end

  // interrupt counter 0
  wire cnt_active = is_motion && cnt_mode;
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      setpoint_r  <= `ACB_RESET_WORD;
      present_r   <= `ACB_RESET_WORD;
      irq_task0_o <= 1'b0;
    end
    else
    begin
      if (we_sp)
        setpoint_r <= merge16(setpoint_r, wr_data_r, wr_strb_r);
      irq_task0_o <= 1'b0;
      if (!cnt_active)
        present_r <= setpoint_r;
      else if (irq_edge)
      begin
        if (present_r <= 16'h0001)
        begin
          present_r   <= setpoint_r;
          irq_task0_o <= 1'b1;
        end
        else
          present_r <= present_r - 16'h0001;
      end
    end
  end

endmodule // acb_aux_bank

// >>> design/acb_regs.vh
// register indexes, field positions, reset values and timing for the aux control bank
`ifndef ACB_REGS_VH
`define ACB_REGS_VH
// register indexes; byte address is four times the index
`define ACB_IDX_AREA_ID_FIRST  10'h1cd
`define ACB_IDX_AREA_ID_LAST   10'h1d9
`define ACB_IDX_LOG_CTRL       10'h1f4
`define ACB_IDX_BUS_RESTART    10'h1f5
`define ACB_IDX_SPEC_FIRST     10'h1f6
`define ACB_IDX_SPEC_LAST      10'h1fb
`define ACB_IDX_TRACE          10'h1fc
`define ACB_IDX_PORT_RESTART   10'h20e
`define ACB_IDX_EDIT_LOCK      10'h20f
`define ACB_IDX_PORT_ERR       10'h210
`define ACB_IDX_CNT0_SETPOINT  10'h214
`define ACB_IDX_CNT0_PRESENT   10'h218
`define ACB_IDX_TRACE_CFG      10'h220
`define ACB_IDX_TRACE_DELAY    10'h221
`define ACB_IDX_LOG_PTR        10'h222
// field positions
`define ACB_LOG_RESET_BIT      14
`define ACB_LOG_NOT_HELD_BIT   15
`define ACB_TR_DIFF_DONE_BIT   9
`define ACB_TR_TRIG_SEEN_BIT   11
`define ACB_TR_DONE_BIT        12
`define ACB_TR_BUSY_BIT        13
`define ACB_TR_TRIGGER_BIT     14
`define ACB_TR_START_BIT       15
`define ACB_PR_SERIAL_BIT      0
`define ACB_PR_PERIPH_BIT      1
`define ACB_PR_DIFF_BIT        7
`define ACB_PE_SERIAL_LSB      2
`define ACB_PE_PERIPH_LSB      10
`define ACB_LOCK_BIT           9
`define ACB_CFG_METHOD_LSB     0
`define ACB_CFG_INTERVAL_LSB   8
// values
`define ACB_AREA_ID_BASE       16'h0050
`define ACB_LOCK_VALIDATOR     8'h5a
`define ACB_SPEC_FIRST_UNIT    10
`define ACB_METHOD_INTERVAL    2'h0
`define ACB_METHOD_INSTR       2'h1
`define ACB_METHOD_CYCLE_END   2'h2
`define ACB_RESET_WORD         16'h0000
`define ACB_RESET_CFG          16'h0100
`define ACB_RESP_OKAY          2'h0
`define ACB_RESP_SLVERR        2'h2
// timing: interval unit 10 ms at a 10 MHz clock
`define ACB_INTERVAL_UNIT_US   10000
`define ACB_CLK_MHZ            10
`endif

// >>> test/acb_aux_bank_sva.sv
// assertion checker for the aux control bank ports
`timescale 1ns/1ns
module acb_aux_bank_sva (
  // clock and reset
  input wire        clk_i,
  input wire        reset_i,
  // bus handshake
  input wire        s_axi_awvalid_i,
  input wire        s_axi_bvalid_o,
  // pins
  input wire        is_motion_i,
  input wire [2:0]  port_restart_done_i,
  // outputs
  input wire [15:0] error_log_pointer_o,
  input wire [15:0] bus_unit_restart_o,
  input wire [95:0] special_unit_restart_o,
  input wire [2:0]  port_restart_o,
  input wire        edit_refuse_o,
  input wire        trace_trigger_o,
  input wire        irq_task0_o
);
  reg bv_q_r;
  reg bv_qq_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // delayed response strobe marks the cycle a lock write reaches edit_refuse_o
  always @(posedge clk_i)
  begin
    bv_q_r  <= s_axi_bvalid_o;
    bv_qq_r <= bv_q_r;
  end
  sequence s_write_done;
    bv_q_r && !bv_qq_r;
  endsequence
  sequence s_done_rise;
    $rose(port_restart_done_i[1]) && !s_axi_awvalid_i;
  endsequence
  property p_lock_by_write;
    $changed(edit_refuse_o) |-> s_write_done;
  endproperty
  property p_restart_clear;
    s_done_rise |-> ##[1:6] !port_restart_o[1];
  endproperty
  property p_restart_set;
    |(port_restart_o & ~$past(port_restart_o)) |-> $rose(s_axi_bvalid_o);
  endproperty
  property p_bus_hold;
    $changed(bus_unit_restart_o) |-> $rose(s_axi_bvalid_o);
  endproperty
  property p_spec_hold;
    $changed(special_unit_restart_o) |-> $rose(s_axi_bvalid_o);
  endproperty
  property p_spec_low;
    special_unit_restart_o[9:0] == 10'h000;
  endproperty
  property p_irq_pulse;
    irq_task0_o |=> !irq_task0_o;
  endproperty
  property p_irq_coord;
    !is_motion_i [*8] |=> !irq_task0_o;
  endproperty
  property p_trig_pulse;
    trace_trigger_o |=> !trace_trigger_o;
  endproperty
  property p_log_ptr;
    $changed(error_log_pointer_o) |->
      error_log_pointer_o == $past(error_log_pointer_o) + 16'h0001 ||
      error_log_pointer_o == 16'h0000;
  endproperty
  a_lock_by_write: assert property (p_lock_by_write) else $error("lock moved");
  a_restart_clear: assert property (p_restart_clear) else $error("restart kept");
  a_restart_set: assert property (p_restart_set) else $error("restart rose");
  a_bus_hold: assert property (p_bus_hold) else $error("bus restart moved");
  a_spec_hold: assert property (p_spec_hold) else $error("spec restart moved");
  a_spec_low: assert property (p_spec_low) else $error("spec low bits set");
  a_irq_pulse: assert property (p_irq_pulse) else $error("task pulse long");
  a_irq_coord: assert property (p_irq_coord) else $error("coordinator fired");
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger long");
  a_log_ptr: assert property (p_log_ptr) else $error("pointer jumped");
endmodule // acb_aux_bank_sva
bind acb_aux_bank acb_aux_bank_sva i_sva (
  .clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_bvalid_o, .is_motion_i,
  .port_restart_done_i, .error_log_pointer_o, .bus_unit_restart_o,
  .special_unit_restart_o, .port_restart_o, .edit_refuse_o,
  .trace_trigger_o, .irq_task0_o
);

// >>> test/tb_top.sv
// self-checking bench for the aux control bank
`timescale 1ns/1ns
`include "acb_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  reg         clk_i = 0;
  reg         reset_i = 1;
  reg  [11:0] s_axi_awaddr_i = 0;
  reg  [11:0] s_axi_araddr_i = 0;
  reg  [31:0] s_axi_wdata_i = 0;
  reg         s_axi_awvalid_i = 0;
  reg         s_axi_wvalid_i = 0;
  reg         s_axi_bready_i = 0;
  reg         s_axi_arvalid_i = 0;
  reg         s_axi_rready_i = 0;
  reg         tool_sel_i = 0;
  reg         is_motion_i = 1;
  reg         counter_mode_i = 0;
  reg  [19:0] ev = 0;
  wire        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [15:0] error_log_pointer_o, bus_unit_restart_o;
  wire [95:0] special_unit_restart_o;
  wire [2:0]  port_restart_o;
  wire        edit_refuse_o, trace_sample_o, trace_sample_valid_o, trace_trigger_o, irq_task0_o;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         seed;
  reg  [17:0] q[$];
  reg  [17:0] e;
  reg  [7:0]  fires = 0;
  reg  [7:0]  smp = 0, vld = 0, trg = 0, n0, v0;
  reg  [9:0]  i;
  reg  [15:0] d;
  acb_aux_bank #(.TICK_CYCLES(20)) i_dut (
    .clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0), .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arprot_i(3'h0), .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .tool_sel_i, .mem_lost_i(ev[0]),
    .err_logged_i(ev[1]), .is_motion_i, .diff_mon_start_i(ev[2]), .diff_mon_hit_i(ev[3]),
    .trace_region_full_i(ev[4]), .trace_finished_i(ev[5]), .trace_sample_instr_i(ev[18]),
    .cycle_end_i(ev[19]), .port_restart_done_i(ev[9:7]), .serial_err_i(ev[13:10]),
    .periph_err_i(ev[17:14]), .irq_in0_i(ev[6]), .counter_mode_i, .error_log_pointer_o,
    .bus_unit_restart_o, .special_unit_restart_o, .port_restart_o, .edit_refuse_o,
    .trace_sample_o, .trace_sample_valid_o, .trace_trigger_o, .irq_task0_o
  );
  always #50 clk_i = ~clk_i;
  task results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // event pins are held two cycles, then given time to pass the synchronisers
  task pulse(input [19:0] m);
    ev <= m;
    tick(2);
    ev <= 20'h0;
    tick(6);
  endtask
  task automatic wr(input [9:0] idx, input [15:0] v);
    int n;
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {16'h0, v};
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 0;
      if (s_axi_bvalid_o === 1'b1)
      begin
        `CHK(s_axi_bresp_o, `ACB_RESP_OKAY)
        return;
      end
    end
    num_errors++;
    results();
  endtask
  task automatic rd(input [9:0] idx, input [15:0] v, input [1:0] resp);
    int n;
    q.push_back({resp, v});
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 0;
      if (s_axi_rvalid_o === 1'b1)
      begin
        return;
      end
    end
    num_errors++;
    results();
  endtask
  // read results are matched against the oldest note
  always @(posedge clk_i)
  begin
    if (irq_task0_o === 1'b1)
      fires <= fires + 8'd1;
    if (trace_sample_o === 1'b1)
      smp <= smp + 8'd1;
    if (trace_sample_valid_o === 1'b1)
      vld <= vld + 8'd1;
    if (trace_trigger_o === 1'b1)
      trg <= trg + 8'd1;
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
    begin
      e = q.pop_front();
      `CHK({s_axi_rresp_o, s_axi_rdata_o}, {e[17:16], 16'h0, e[15:0]})
    end
  end
  initial
  begin
    seed = 83;
    tick(3);
    reset_i <= 0;
    tick(1);
    for (i = 0; i < 13; i++)
      rd(`ACB_IDX_AREA_ID_FIRST + i, `ACB_AREA_ID_BASE + {6'h0, i}, `ACB_RESP_OKAY);
    rd(10'h100, 16'h0000, `ACB_RESP_SLVERR);
    d = 16'($random(seed));
    wr(`ACB_IDX_BUS_RESTART, d);
    rd(`ACB_IDX_BUS_RESTART, d, `ACB_RESP_OKAY);
    `CHK(bus_unit_restart_o, d)
    for (i = 0; i < 6; i++)
    begin
      d = 16'($random(seed));
      wr(`ACB_IDX_SPEC_FIRST + i, d);
      tick(1);
      `CHK(special_unit_restart_o[16*i +: 16], (i == 0) ? (d & 16'hfc00) : d)
    end
    wr(`ACB_IDX_PORT_RESTART, 16'h0083);
    tick(1);
    `CHK(port_restart_o, 3'h7)
    pulse(20'h00100);
    `CHK(port_restart_o, 3'h5)
    rd(`ACB_IDX_PORT_RESTART, 16'h0081, `ACB_RESP_OKAY);
    for (i = 0; i < 3; i++)
    begin
      wr(`ACB_IDX_EDIT_LOCK, (i == 1) ? 16'h0259 : ((i == 2) ? 16'h005a : 16'h025a));
      tick(2);
      `CHK(edit_refuse_o, i == 0)
    end
    pulse(20'h29400);
    rd(`ACB_IDX_PORT_ERR, 16'h2814, `ACB_RESP_OKAY);
    wr(`ACB_IDX_PORT_ERR, 16'hffff);
    rd(`ACB_IDX_PORT_ERR, 16'h0000, `ACB_RESP_OKAY);
    pulse(20'h2);
    pulse(20'h2);
    pulse(20'h1);
    rd(`ACB_IDX_LOG_PTR, 16'h0002, `ACB_RESP_OKAY);
    rd(`ACB_IDX_LOG_CTRL, 16'h8000, `ACB_RESP_OKAY);
    wr(`ACB_IDX_LOG_CTRL, 16'h4000);
    rd(`ACB_IDX_LOG_CTRL, 16'h4000, `ACB_RESP_OKAY);
    `CHK(error_log_pointer_o, 16'h0000)
    tool_sel_i <= 1;
    tick(4);
    wr(`ACB_IDX_TRACE, 16'h8000);
    tick(6);
    rd(`ACB_IDX_TRACE, 16'ha000, `ACB_RESP_OKAY);
    wr(`ACB_IDX_TRACE, 16'hc000);
    tick(6);
    rd(`ACB_IDX_TRACE, 16'he800, `ACB_RESP_OKAY);
    `CHK(trg, 8'd1)
    pulse(20'h10);
    rd(`ACB_IDX_TRACE, 16'hf800, `ACB_RESP_OKAY);
    pulse(20'h20);
    rd(`ACB_IDX_TRACE, 16'hd800, `ACB_RESP_OKAY);
    tool_sel_i <= 0;
    tick(4);
    wr(`ACB_IDX_TRACE, 16'h0000);
    rd(`ACB_IDX_TRACE, 16'h9800, `ACB_RESP_OKAY);
    tool_sel_i <= 1;
    tick(4);
    wr(`ACB_IDX_TRACE, 16'h0000);
    wr(`ACB_IDX_TRACE, 16'h8000);
    tick(6);
    rd(`ACB_IDX_TRACE, 16'ha000, `ACB_RESP_OKAY);
    pulse(20'h8);
    rd(`ACB_IDX_TRACE, 16'ha200, `ACB_RESP_OKAY);
    pulse(20'h4);
    rd(`ACB_IDX_TRACE, 16'ha000, `ACB_RESP_OKAY);
    // instruction method, no trigger seen, delay zero: sample but not valid
    wr(`ACB_IDX_TRACE_CFG, 16'h0101);
    tick(2);
    n0 = smp;
    v0 = vld;
    pulse(20'h40000);
    `CHK(smp, n0 + 8'd1)
    `CHK(vld, v0)
    // cycle-end method with a negative delay: every sample is valid
    wr(`ACB_IDX_TRACE_DELAY, 16'hffff);
    wr(`ACB_IDX_TRACE_CFG, 16'h0102);
    pulse(20'h80000);
    `CHK(smp, n0 + 8'd2)
    `CHK(vld, v0 + 8'd1)
    wr(`ACB_IDX_CNT0_SETPOINT, 16'h0003);
    counter_mode_i <= 1;
    tick(4);
    repeat (6) pulse(20'h40);
    `CHK(fires, 8'd2)
    is_motion_i <= 0;
    tick(4);
    repeat (3) pulse(20'h40);
    `CHK(fires, 8'd2)
    tick(2);
    `CHK(q.size(), 0)
    results();
  end
endmodule // tb_top
